/* File: core_seq_model.sv */
// Behavioural core sequencer that feeds operations to the program counter unit
`default_nettype none
module core_seq_model
   import pcstk_pkg::*;
#(
   parameter logic [20:0] IRQ_VECTOR = 21'h000008
) (
   // Requests from the bench
   input  wire logic        i_irq_req,
   input  wire logic        i_gie,
   input  wire pc_op_e      i_op_req,
   input  wire logic [20:0] i_tgt_req,
   // Operation to the unit
   output pc_op_e           o_op,
   output logic [20:0]      o_target
);
   // Acknowledge replaces the instruction; masked while the global enable i_gie is low
   assign o_op     = (i_irq_req && i_gie) ? OP_IRQ : i_op_req;
   assign o_target = (i_irq_req && i_gie) ? IRQ_VECTOR : i_tgt_req;
endmodule // core_seq_model
`default_nettype wire

/* File: flash_partition.sv */
// Program flash region decode, execute refusal and write protection
`default_nettype none
module flash_partition
   import pcstk_pkg::*;
(
   // Configuration
   input  wire logic [20:0] i_last_prog_addr,
   input  wire logic [20:0] i_boot_last_addr,
   input  wire logic        i_boot_region_enable_n,
   input  wire logic        i_data_region_enable_n,
   input  wire logic        i_app_write_protect,
   input  wire logic        i_boot_write_protect,
   input  wire logic        i_data_region_write_protect,
   // Addresses
   input  wire logic [20:0] i_fetch_addr,
   input  wire logic [20:0] i_write_addr,
   // Results
   output region_e          o_fetch_region,
   output logic             o_fetch_refused,
   output logic             o_write_protected
);
   logic [20:0] data_base;
   region_e     write_region;

   // Region decode shared by fetch and write paths
   function automatic region_e decode(input logic [20:0] a, input logic [20:0] dbase,
                                      input logic [20:0] blast, input logic boot_region_enable_n_n,
                                      input logic data_region_enable_n_n);
      if (!data_region_enable_n_n && (a >= dbase)) begin
         decode = REG_DATA;
      end else if (!boot_region_enable_n_n && (a >= BOOT_BASE) && (a <= blast)) begin
         decode = REG_BOOT;
      end else begin
         decode = REG_APP;
      end
   endfunction

   assign data_base       = i_last_prog_addr - DATA_REGION_SPAN;
   assign o_fetch_region  = decode(i_fetch_addr, data_base, i_boot_last_addr,
                                   i_boot_region_enable_n, i_data_region_enable_n);
   assign write_region    = decode(i_write_addr, data_base, i_boot_last_addr,
                                   i_boot_region_enable_n, i_data_region_enable_n);
   assign o_fetch_refused = (o_fetch_region == REG_DATA);
   // Protection per region
   assign o_write_protected = (write_region == REG_DATA) ? i_data_region_write_protect :
                              (write_region == REG_BOOT) ? i_boot_write_protect :
                                                           i_app_write_protect;
endmodule // flash_partition
`default_nettype wire

/* File: pc_return_stack.sv */
// Program counter, latch registers and 31-level return stack unit
`default_nettype none
module pc_return_stack
   import pcstk_pkg::*;
#(
   parameter logic [20:0] LAST_PROG_ADDR = LAST_PROG_ADDR_RST
) (
   // Clock and resets
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_por,
   // Core sequencer
   input  wire pc_op_e      i_op,
   input  wire logic [20:0] i_target,
   // Software register writes and reads
   input  wire logic        i_pc_low_byte_wr,
   input  wire logic [7:0]  i_pc_low_byte_wdata,
   input  wire logic        i_pc_low_byte_rd,
   input  wire logic        i_pc_high_latch_wr,
   input  wire logic [7:0]  i_pc_high_latch_wdata,
   input  wire logic        i_pc_upper_latch_wr,
   input  wire logic [4:0]  i_pc_upper_latch_wdata,
   input  wire logic        i_stack_top_upper_wr,
   input  wire logic        i_stack_top_high_wr,
   input  wire logic        i_stack_top_low_wr,
   input  wire logic [7:0]  i_stack_top_wdata,
   input  wire logic        i_stack_pointer_reg_wr,
   input  wire logic [4:0]  i_stack_pointer_reg_wdata,
   input  wire logic        i_flag_wr,
   input  wire logic        i_stack_overflow_flag_wdata,
   input  wire logic        i_stack_underflow_flag_wdata,
   input  wire logic        i_nvm_write_error_clr,
   // Configuration
   input  wire logic        i_stack_fault_reset_enable,
   input  wire logic        i_boot_region_enable_n,
   input  wire logic        i_data_region_enable_n,
   input  wire logic [20:0] i_boot_last_addr,
   input  wire logic        i_app_write_protect,
   input  wire logic        i_boot_write_protect,
   input  wire logic        i_data_region_write_protect,
   // Flash write request
   input  wire logic        i_nvm_wr_req,
   input  wire logic [20:0] i_nvm_wr_addr,
   output logic             o_nvm_wr_grant,
   output logic             o_nvm_write_error_flag,
   // Program counter view
   output logic [20:0]      o_pc,
   output logic [7:0]       o_pc_low_byte,
   output logic [7:0]       o_pc_high_latch,
   output logic [4:0]       o_pc_upper_latch,
   output logic             o_fetch_refused,
   // Stack view
   output logic [4:0]       o_stack_top_upper,
   output logic [7:0]       o_stack_top_high,
   output logic [7:0]       o_stack_top_low,
   output logic [4:0]       o_stack_pointer_reg,
   output logic             o_stack_overflow_flag,
   output logic             o_stack_underflow_flag,
   output logic             o_stack_fault_reset
);
   // State
   logic [20:0] pc_ff;
   logic [20:0] nxt_pc;
   logic [7:0]  lath_ff;
   logic [7:0]  nxt_lath;
   logic [4:0]  latu_ff;
   logic [4:0]  nxt_latu;
   logic [4:0]  ptr_ff;
   logic [4:0]  nxt_ptr;
   logic        ovf_ff;
   logic        nxt_ovf;
   logic        unf_ff;
   logic        nxt_unf;
   logic        fault_ff;
   logic        nxt_fault;
   logic        nvm_err_ff;

   // Decoded events
   logic        is_push;
   logic        is_pop;
   logic        stack_full;
   logic        stack_empty;
   logic        overflow_evt;
   logic        underflow_evt;
   logic        tos_wr;
   logic [4:0]  push_idx;
   logic [20:0] push_addr;
   logic [20:0] pc_plus;
   logic [20:0] tos_word;
   logic [20:0] tos_merged;
   logic        nvm_protected;

   stack_mem_if smem ();

   // Stack storage, reached only through the selected index
   return_stack_mem #(
      .DEPTH (STACK_DEPTH)
   ) u_mem (
      .i_clk (i_clk),
      .mem   (smem)
   );

   // Flash partition checks
   flash_partition u_part (
      .i_last_prog_addr            (LAST_PROG_ADDR),
      .i_boot_last_addr            (i_boot_last_addr),
      .i_boot_region_enable_n      (i_boot_region_enable_n),
      .i_data_region_enable_n      (i_data_region_enable_n),
      .i_app_write_protect         (i_app_write_protect),
      .i_boot_write_protect        (i_boot_write_protect),
      .i_data_region_write_protect (i_data_region_write_protect),
      .i_fetch_addr                (pc_ff),
      .i_write_addr                (i_nvm_wr_addr),
      .o_fetch_region              (),
      .o_fetch_refused             (o_fetch_refused),
      .o_write_protected           (nvm_protected)
   );

   // Operation decode
   assign is_push       = (i_op == OP_CALL) || (i_op == OP_IRQ);
   assign is_pop        = (i_op == OP_RETURN);
   assign stack_full    = (ptr_ff == PTR_FULL);
   assign stack_empty   = (ptr_ff == PTR_EMPTY);
   assign overflow_evt  = is_push && stack_full;
   assign underflow_evt = is_pop && stack_empty;
   assign tos_wr        = i_stack_top_upper_wr || i_stack_top_high_wr || i_stack_top_low_wr;
   assign pc_plus       = pc_ff + PC_STEP;

   // Call pushes the next instruction, an interrupt the one it preempted
   assign push_addr = (i_op == OP_CALL) ? pc_plus : pc_ff;
   assign push_idx  = stack_full ? PTR_FULL : ptr_ff + 5'h01;

   // Selected entry as seen by software
   assign tos_word   = smem.rd_data;
   assign tos_merged = {i_stack_top_upper_wr ? i_stack_top_wdata[UPR_W-1:0]
                                             : tos_word[20:16],
                        i_stack_top_high_wr  ? i_stack_top_wdata : tos_word[15:8],
                        i_stack_top_low_wr   ? i_stack_top_wdata : tos_word[7:0]};

   // Storage port: pushes win, software writes only when no push
   assign smem.rd_idx  = ptr_ff;
   assign smem.wr_en   = (is_push && !(overflow_evt && i_stack_fault_reset_enable))
                         || (!is_push && !is_pop && tos_wr && !stack_empty);
   assign smem.wr_idx  = is_push ? push_idx : ptr_ff;
   assign smem.wr_data = is_push ? push_addr : tos_merged;

   // Program counter next value
   always_comb begin
      nxt_pc = pc_ff;
      unique case (i_op)
         OP_IDLE:   nxt_pc = pc_ff;
         OP_SEQ:    nxt_pc = pc_plus;
         OP_JUMP:   nxt_pc = i_target;
         OP_CALL:   nxt_pc = i_target;
         OP_IRQ:    nxt_pc = i_target;
         OP_RETURN: nxt_pc = stack_empty ? UNDERFLOW_PC : tos_word;
         OP_PCL_WR: nxt_pc = {latu_ff, lath_ff, i_pc_low_byte_wdata};
         default:   nxt_pc = pc_ff;
      endcase
      if (i_op == OP_IDLE && i_pc_low_byte_wr) begin
         nxt_pc = {latu_ff, lath_ff, i_pc_low_byte_wdata};
      end
      nxt_pc = nxt_pc & PC_ALIGN_MASK;
   end

   // Latch registers: software writes, low byte read copies; stack ops leave them
   always_comb begin
      nxt_lath = lath_ff;
      nxt_latu = latu_ff;
      if (i_pc_high_latch_wr) begin
         nxt_lath = i_pc_high_latch_wdata;
      end
      if (i_pc_upper_latch_wr) begin
         nxt_latu = i_pc_upper_latch_wdata;
      end
      if (i_pc_low_byte_rd) begin
         nxt_lath = pc_ff[15:8];
         nxt_latu = pc_ff[20:16];
      end
   end

   // Stack pointer
   always_comb begin
      nxt_ptr = ptr_ff;
      if (is_push) begin
         if (!stack_full) begin
            nxt_ptr = ptr_ff + 5'h01;
         end else if (i_stack_fault_reset_enable) begin
            nxt_ptr = PTR_EMPTY;
         end else begin
            nxt_ptr = PTR_FULL;
         end
      end else if (is_pop) begin
         if (!stack_empty) begin
            nxt_ptr = ptr_ff - 5'h01;
         end
      end else if (i_stack_pointer_reg_wr) begin
         nxt_ptr = i_stack_pointer_reg_wdata;
      end
   end

   // Flags: software writes, hardware set wins over a clear
   always_comb begin
      nxt_ovf = ovf_ff;
      nxt_unf = unf_ff;
      if (i_flag_wr) begin
         nxt_ovf = i_stack_overflow_flag_wdata;
         nxt_unf = i_stack_underflow_flag_wdata;
      end
      if (overflow_evt) begin
         nxt_ovf = 1'b1;
      end
      if (underflow_evt) begin
         nxt_unf = 1'b1;
      end
   end

   // Reset request only from hardware faults, never from a software flag write
   assign nxt_fault = i_stack_fault_reset_enable && (overflow_evt || underflow_evt);

   // Counter, latches and pointer: cleared by every reset
   always_ff @(posedge i_clk) begin
      if (i_rst || i_por) begin
         pc_ff    <= PC_RST;
         lath_ff  <= LATH_RST;
         latu_ff  <= LATU_RST;
         ptr_ff   <= PTR_EMPTY;
         fault_ff <= 1'b0;
      end else begin
         pc_ff    <= nxt_pc;
         lath_ff  <= nxt_lath;
         latu_ff  <= nxt_latu;
         ptr_ff   <= nxt_ptr;
         fault_ff <= nxt_fault;
      end
   end

   // Flags survive the device reset, cleared only at power-on
   always_ff @(posedge i_clk) begin
      if (i_por) begin
         ovf_ff <= 1'b0;
         unf_ff <= 1'b0;
      end else begin
         ovf_ff <= nxt_ovf;
         unf_ff <= nxt_unf;
      end
   end

   // Write error flag: set on a refused write, set wins over clear
   always_ff @(posedge i_clk) begin
      if (i_por) begin
         nvm_err_ff <= 1'b0;
      end else if (i_nvm_wr_req && nvm_protected) begin
         nvm_err_ff <= 1'b1;
      end else if (i_nvm_write_error_clr) begin
         nvm_err_ff <= 1'b0;
      end
   end

   // Write grant to the flash engine, withheld for protected locations
   assign o_nvm_wr_grant         = i_nvm_wr_req && !nvm_protected;
   assign o_nvm_write_error_flag = nvm_err_ff;

   // Register views
   assign o_pc                   = pc_ff;
   assign o_pc_low_byte          = pc_ff[7:0];
   assign o_pc_high_latch        = lath_ff;
   assign o_pc_upper_latch       = latu_ff;
   assign o_stack_top_upper      = tos_word[20:16];
   assign o_stack_top_high       = tos_word[15:8];
   assign o_stack_top_low        = tos_word[7:0];
   assign o_stack_pointer_reg    = ptr_ff;
   assign o_stack_overflow_flag  = ovf_ff;
   assign o_stack_underflow_flag = unf_ff;
   assign o_stack_fault_reset    = fault_ff;
endmodule // pc_return_stack
`default_nettype wire

/* File: pc_return_stack_assertions.sv */
// Port-level assertions for the program counter and return stack unit
`default_nettype none
module pc_return_stack_checker
   import pcstk_pkg::*;
#(
   parameter logic [20:0] LAST_PROG_ADDR = LAST_PROG_ADDR_RST
) (
   // Clock and resets
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_por,
   // Watched inputs
   input wire pc_op_e      i_op,
   input wire logic [20:0] i_target,
   input wire logic        i_pc_low_byte_wr,
   input wire logic [7:0]  i_pc_low_byte_wdata,
   input wire logic        i_pc_low_byte_rd,
   input wire logic        i_pc_high_latch_wr,
   input wire logic        i_pc_upper_latch_wr,
   input wire logic        i_flag_wr,
   input wire logic        i_stack_overflow_flag_wdata,
   input wire logic        i_stack_fault_reset_enable,
   input wire logic        i_data_region_enable_n,
   // Watched outputs
   input wire logic [20:0] o_pc,
   input wire logic [7:0]  o_pc_high_latch,
   input wire logic [4:0]  o_pc_upper_latch,
   input wire logic        o_fetch_refused,
   input wire logic [4:0]  o_stack_top_upper,
   input wire logic [7:0]  o_stack_top_high,
   input wire logic [7:0]  o_stack_top_low,
   input wire logic [4:0]  o_stack_pointer_reg,
   input wire logic        o_stack_overflow_flag,
   input wire logic        o_stack_underflow_flag,
   input wire logic        o_stack_fault_reset
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst || i_por);
   // Helper views
   wire logic [20:0] top   = {o_stack_top_upper, o_stack_top_high, o_stack_top_low};
   wire logic        quiet = !i_pc_low_byte_rd && !i_pc_high_latch_wr && !i_pc_upper_latch_wr;
   wire logic        full  = o_stack_pointer_reg == PTR_FULL;
   // Push and pop causes
   sequence call_s;
      i_op == OP_CALL && !full;
   endsequence
   sequence pop_s;
      i_op == OP_RETURN && o_stack_pointer_reg != PTR_EMPTY;
   endsequence
   sequence full_push_s;
      (i_op == OP_CALL || i_op == OP_IRQ) && full;
   endsequence
   AST_SEQ_STEP: assert property (i_op == OP_SEQ |=> o_pc == $past(o_pc) + PC_STEP && !o_pc[0])
      else $error("sequential step wrong");
   AST_JUMP_LOAD: assert property (i_op == OP_JUMP |=> o_pc == ($past(i_target) & PC_ALIGN_MASK))
      else $error("jump target not loaded");
   AST_CALL_PUSH: assert property (call_s |=> o_stack_pointer_reg == $past(o_stack_pointer_reg)
      + 5'h01 && top == $past(o_pc) + PC_STEP && o_pc == $past(i_target))
      else $error("call push wrong");
   AST_IRQ_PUSH: assert property (i_op == OP_IRQ && !full |=> top == $past(o_pc))
      else $error("interrupt push wrong");
   AST_RET_POP: assert property (pop_s |=> o_pc == $past(top)
      && o_stack_pointer_reg == $past(o_stack_pointer_reg) - 5'h01)
      else $error("return pop wrong");
   AST_LATCH_HOLD: assert property (i_op inside {OP_CALL, OP_IRQ, OP_RETURN} && quiet
      |=> $stable(o_pc_high_latch) && $stable(o_pc_upper_latch))
      else $error("latch changed by call or return");
   AST_LOW_WRITE: assert property (i_op == OP_IDLE && i_pc_low_byte_wr |=> o_pc == {$past(
      o_pc_upper_latch), $past(o_pc_high_latch), $past(i_pc_low_byte_wdata) & 8'hfe})
      else $error("low byte write did not load latches");
   AST_LOW_READ: assert property (i_pc_low_byte_rd |=> o_pc_high_latch == $past(o_pc[15:8])
      && o_pc_upper_latch == $past(o_pc[20:16]))
      else $error("low byte read did not fill latches");
   AST_OVERFLOW: assert property (full_push_s |=> o_stack_overflow_flag && o_stack_fault_reset
      == $past(i_stack_fault_reset_enable) && o_stack_pointer_reg
      == ($past(i_stack_fault_reset_enable) ? PTR_EMPTY : PTR_FULL))
      else $error("overflow handling wrong");
   AST_UNDERFLOW: assert property (i_op == OP_RETURN && o_stack_pointer_reg == PTR_EMPTY
      |=> o_pc == UNDERFLOW_PC && o_stack_underflow_flag
      && o_stack_fault_reset == $past(i_stack_fault_reset_enable))
      else $error("underflow handling wrong");
   AST_SW_FLAG: assert property (i_flag_wr && i_stack_overflow_flag_wdata && i_op == OP_IDLE
      |=> o_stack_overflow_flag && !o_stack_fault_reset)
      else $error("software overflow set misbehaved");
   AST_REFUSE: assert property (o_fetch_refused == (!i_data_region_enable_n
      && o_pc >= LAST_PROG_ADDR - DATA_REGION_SPAN))
      else $error("fetch refusal wrong");
   AST_RESET_PTR: assert property (disable iff (1'b0) i_rst || i_por
      |=> o_stack_pointer_reg == PTR_EMPTY && !o_stack_fault_reset)
      else $error("pointer not cleared by reset");
endmodule // pc_return_stack_checker
bind pc_return_stack pc_return_stack_checker #(.LAST_PROG_ADDR(LAST_PROG_ADDR)) chk_u (.*);
`default_nettype wire

/* File: pc_return_stack_bench.sv */
// Self-checking bench for the program counter and return stack unit
`default_nettype none
module pc_return_stack_bench
   import pcstk_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Strobe codes for the software access task
   localparam logic [8:0] W_LO = 9'h001, R_LO = 9'h002, W_LAT = 9'h00c, W_TU = 9'h010;
   localparam logic [8:0] W_TH = 9'h020, W_TL = 9'h040, W_SP = 9'h080, W_FL = 9'h100;
   // Clock, resets and sequencer requests
   logic i_clk = 1'b0, i_rst = 1'b1, i_por = 1'b1, irq_req = 1'b0, global_irq_enable = 1'b1;
   pc_op_e      i_op, op_req = OP_IDLE;
   logic [20:0] i_target, tgt_req = 21'h000000;
   // Software strobes and data
   logic i_pc_low_byte_wr = 1'b0, i_pc_low_byte_rd = 1'b0, i_pc_high_latch_wr = 1'b0;
   logic i_pc_upper_latch_wr = 1'b0, i_stack_top_upper_wr = 1'b0, i_stack_top_high_wr = 1'b0;
   logic i_stack_top_low_wr = 1'b0, i_stack_pointer_reg_wr = 1'b0, i_flag_wr = 1'b0;
   logic i_stack_overflow_flag_wdata = 1'b0, i_stack_underflow_flag_wdata = 1'b0;
   logic [7:0] i_pc_low_byte_wdata = 8'h00, i_pc_high_latch_wdata = 8'h00;
   logic [7:0] i_stack_top_wdata = 8'h00;
   logic [4:0] i_pc_upper_latch_wdata = 5'h00, i_stack_pointer_reg_wdata = 5'h00;
   // Configuration and flash writes
   logic i_nvm_write_error_clr = 1'b0, i_stack_fault_reset_enable = 1'b1, i_nvm_wr_req = 1'b0;
   logic i_boot_region_enable_n = 1'b1, i_data_region_enable_n = 1'b1, i_app_write_protect = 1'b0;
   logic i_boot_write_protect = 1'b1, i_data_region_write_protect = 1'b1;
   logic [20:0] i_boot_last_addr = 21'h0007ff, i_nvm_wr_addr = 21'h000000;
   // Design outputs
   logic [20:0] o_pc;
   logic [7:0]  o_pc_low_byte, o_pc_high_latch, o_stack_top_high, o_stack_top_low;
   logic [4:0]  o_pc_upper_latch, o_stack_top_upper, o_stack_pointer_reg;
   logic o_nvm_wr_grant, o_nvm_write_error_flag, o_fetch_refused, o_stack_overflow_flag;
   logic o_stack_underflow_flag, o_stack_fault_reset;
   int   n_mismatch = 0, samples_checked = 0;
   // Short views for comparisons
   wire logic [20:0] stack_top = {o_stack_top_upper, o_stack_top_high, o_stack_top_low};
   wire logic [20:0] sp  = 21'(o_stack_pointer_reg);
   wire logic [20:0] lat = 21'({o_pc_upper_latch, o_pc_high_latch});
   wire logic [20:0] flg = 21'({o_stack_overflow_flag, o_stack_underflow_flag,
                                o_stack_fault_reset});
   // Far-side sequencer and the unit
   core_seq_model seq_u (.i_irq_req(irq_req), .i_gie(global_irq_enable), .i_op_req(op_req),
                         .i_tgt_req(tgt_req), .o_op(i_op), .o_target(i_target));
   pc_return_stack dut_u (.*);
   always #2.5 i_clk = ~i_clk;
   // Compare and count
   task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // One core operation, issued after a falling edge
   task automatic run(input pc_op_e o, input logic [20:0] t);
      op_req = o;
      tgt_req = t;
      @(negedge i_clk);
   endtask
   // One software access with its strobes released a cycle later
   task automatic sw(input logic [8:0] s, input logic [7:0] d, input logic [4:0] u);
      op_req = OP_IDLE;
      {i_flag_wr, i_stack_pointer_reg_wr, i_stack_top_low_wr, i_stack_top_high_wr,
       i_stack_top_upper_wr, i_pc_upper_latch_wr, i_pc_high_latch_wr, i_pc_low_byte_rd,
       i_pc_low_byte_wr} = s;
      {i_pc_low_byte_wdata, i_pc_high_latch_wdata, i_stack_top_wdata} = {d, d, d};
      {i_pc_upper_latch_wdata, i_stack_pointer_reg_wdata} = {u, u};
      {i_stack_overflow_flag_wdata, i_stack_underflow_flag_wdata} = d[1:0];
      @(negedge i_clk);
      {i_flag_wr, i_stack_pointer_reg_wr, i_stack_top_low_wr, i_stack_top_high_wr,
       i_stack_top_upper_wr, i_pc_upper_latch_wr, i_pc_high_latch_wr, i_pc_low_byte_rd,
       i_pc_low_byte_wr} = 9'h000;
      @(negedge i_clk);
   endtask
   // Flash write request, then clear of the error flag
   task automatic nvm(input logic [20:0] a, input logic g);
      op_req = OP_IDLE;
      i_nvm_wr_addr = a;
      i_nvm_wr_req = 1'b1;
      #1;
      chk(21'(o_nvm_wr_grant), 21'(g), "grant");
      @(negedge i_clk);
      i_nvm_wr_req = 1'b0;
      i_nvm_write_error_clr = 1'b1;
      chk(21'(o_nvm_write_error_flag), 21'(!g), "write error");
      @(negedge i_clk);
      i_nvm_write_error_clr = 1'b0;
   endtask
   task automatic tdone(input string n);
      $display("test %s done, mismatches %0d", n, n_mismatch);
   endtask
   // Verdict and end of run
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Watchdog against a hung run
   initial begin
      repeat (20000) @(posedge i_clk);
      n_mismatch++;
      end_sim();
   end
   // Main test sequence
   initial begin
      repeat (3) @(negedge i_clk);
      {i_rst, i_por} = 2'b00;
      chk(o_pc | sp, 21'h000000, "reset");
      run(OP_SEQ, 21'h000000);
      run(OP_SEQ, 21'h000000);
      chk(o_pc, 21'h000004, "sequential");
      run(OP_JUMP, 21'h012346);
      chk(o_pc | lat, 21'h012346, "jump");
      chk(21'(o_pc_low_byte), 21'h000046, "low byte view");
      sw(W_LAT, 8'hab, 5'h03);
      chk(o_pc, 21'h012346, "latch write only");
      sw(W_LO, 8'h55, 5'h00);
      chk(o_pc, 21'h03ab54, "low byte write");
      i_pc_low_byte_wdata = 8'h21;
      run(OP_PCL_WR, 21'h000000);
      chk(o_pc, 21'h03ab20, "op low write");
      run(OP_JUMP, 21'h1cde10);
      sw(R_LO, 8'h00, 5'h00);
      chk(lat, 21'h001cde, "low byte read");
      tdone("counter");
      run(OP_CALL, 21'h000200);
      chk(sp, 21'h000001, "push pointer");
      chk(stack_top, 21'h1cde12, "push value");
      irq_req = 1'b1;
      run(OP_SEQ, 21'h000000);
      chk(stack_top | o_pc, 21'h000208, "irq push");
      global_irq_enable = 1'b0;
      run(OP_SEQ, 21'h000000);
      chk(o_pc | sp, 21'h00000a, "irq masked");
      irq_req = 1'b0;
      global_irq_enable = 1'b1;
      run(OP_RETURN, 21'h000000);
      chk(o_pc, 21'h000200, "first return");
      run(OP_RETURN, 21'h000000);
      chk(o_pc | sp, 21'h1cde12, "second return");
      chk(lat, 21'h001cde, "latches kept");
      sw(W_SP, 8'h00, 5'h02);
      sw(W_TL, 8'h78, 5'h00);
      sw(W_TH, 8'h56, 5'h00);
      sw(W_TU, 8'h14, 5'h00);
      chk(stack_top, 21'h145678, "top write");
      chk(sp, 21'h000002, "pointer write");
      run(OP_RETURN, 21'h000000);
      chk(o_pc | sp, 21'h145679, "return top");
      tdone("stack");
      for (int e = 1; e >= 0; e--) begin
         i_stack_fault_reset_enable = e[0];
         sw(W_SP | W_FL, 8'h00, 5'h00);
         for (int i = 0; i < 31; i++) begin
            run(OP_CALL, 21'h000100);
         end
         chk(sp | flg, 21'h00001f, "31 pushes");
         run(OP_JUMP, 21'h000400);
         run(OP_CALL, 21'h000300);
         chk(sp | (flg << 5), e ? 21'h0000a0 : 21'h00009f, "32nd push");
         if (e == 0) chk(stack_top, 21'h000402, "entry overwritten");
         run(OP_IDLE, 21'h000000);
         chk(flg, 21'h000004, "overflow held");
      end
      sw(W_FL, 8'h00, 5'h00);
      sw(W_FL, 8'h02, 5'h00);
      chk(flg, 21'h000004, "software set");
      i_rst = 1'b1;
      @(negedge i_clk);
      i_rst = 1'b0;
      chk(flg | sp, 21'h000004, "flags kept by reset");
      i_por = 1'b1;
      @(negedge i_clk);
      i_por = 1'b0;
      chk(flg, 21'h000000, "flags cleared by power-on");
      for (int e = 1; e >= 0; e--) begin
         i_stack_fault_reset_enable = e[0];
         run(OP_JUMP, 21'h000500);
         run(OP_RETURN, 21'h000000);
         chk(flg | o_pc, e ? 21'h000003 : 21'h000002, "underflow");
         sw(W_FL, 8'h00, 5'h00);
      end
      tdone("faults");
      i_data_region_enable_n = 1'b0;
      run(OP_JUMP, 21'h01ff02);
      chk(21'(o_fetch_refused), 21'h000001, "data fetch");
      run(OP_JUMP, 21'h01fefe);
      chk(21'(o_fetch_refused), 21'h000000, "app fetch");
      nvm(21'h01ff10, 1'b0);
      nvm(21'h001000, 1'b1);
      i_data_region_enable_n = 1'b1;
      nvm(21'h01ff10, 1'b1);
      i_boot_region_enable_n = 1'b0;
      nvm(21'h000100, 1'b0);
      tdone("flash");
      end_sim();
   end
endmodule // pc_return_stack_bench
`default_nettype wire

/* File: pcstk_pkg.sv */
// Shared constants and types for the program counter and return stack unit
`default_nettype none
package pcstk_pkg;
   // Widths
   localparam int PC_W   = 21;
   localparam int PTR_W  = 5;
   localparam int BYTE_W = 8;
   localparam int UPR_W  = 5;
   // Stack geometry and pointer codes
   localparam int             STACK_DEPTH = 31;
   localparam logic [4:0]     PTR_EMPTY   = 5'h00;
   localparam logic [4:0]     PTR_FULL    = 5'h1f;
   // Values after reset and after an underflow return
   localparam logic [20:0]    PC_RST      = 21'h000000;
   localparam logic [7:0]     LATH_RST    = 8'h00;
   localparam logic [4:0]     LATU_RST    = 5'h00;
   localparam logic [20:0]    UNDERFLOW_PC = 21'h000000;
   // Byte addressing: one instruction word is two bytes
   localparam logic [20:0]    PC_STEP     = 21'h000002;
   localparam logic [20:0]    PC_ALIGN_MASK = 21'h1ffffe;
   // Flash partition
   localparam logic [20:0]    BOOT_BASE   = 21'h000000;
   localparam logic [20:0]    DATA_REGION_SPAN = 21'h0000fe; // Last 127 words, byte offset
   localparam logic [20:0]    LAST_PROG_ADDR_RST = 21'h01ffff;
   // Core sequencer operations
   typedef enum logic [2:0] {
      OP_IDLE   = 3'h0,
      OP_SEQ    = 3'h1,
      OP_JUMP   = 3'h3,
      OP_CALL   = 3'h2,
      OP_IRQ    = 3'h6,
      OP_RETURN = 3'h7,
      OP_PCL_WR = 3'h5
   } pc_op_e;
   // Flash regions
   typedef enum logic [1:0] {
      REG_APP  = 2'h0,
      REG_BOOT = 2'h1,
      REG_DATA = 2'h3
   } region_e;
endpackage
`default_nettype wire

/* File: return_stack_mem.sv */
// Return address storage: entries 1..31, index 0 has no storage
`default_nettype none
module return_stack_mem
   import pcstk_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   // Clock
   input  wire logic  i_clk,
   // Storage port
   stack_mem_if.mem   mem
);
   logic [PC_W-1:0] entry_ff [1:DEPTH];

   // One register per entry, written when its index is selected
   genvar g;
   generate
      for (g = 1; g <= DEPTH; g++) begin : g_entry
         always_ff @(posedge i_clk) begin
            if (mem.wr_en && (mem.wr_idx == PTR_W'(g))) begin
               entry_ff[g] <= mem.wr_data;
            end
         end
      end
   endgenerate

   // Pointer zero reads as zero
   assign mem.rd_data = (mem.rd_idx == PTR_EMPTY) ? '0 : entry_ff[mem.rd_idx];
endmodule // return_stack_mem
`default_nettype wire

/* File: stack_mem_if.sv */
// Carrier between the stack controller and the stack storage
`default_nettype none
interface stack_mem_if;
   logic        wr_en;
   logic [4:0]  wr_idx;
   logic [20:0] wr_data;
   logic [4:0]  rd_idx;
   logic [20:0] rd_data;
   modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
   modport mem  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire
